// *** design/sarseq_top.sv ***
// Digital control of a 12-bit SAR converter with a 9-source sequencer.
// Assumes an AHB-Lite master and an analog front end driven by ana_o.
//
// Summary of operation
// RULE1 - Produces 12-bit results at up to one million samples per second; the code tops out at about 926 ksps (100 MHz / 6 / 18).
// RULE2 - Converter clock at most 18 MHz; each conversion lasts 18 clocks or more.
// RULE3 - Reference select: supply, half supply, internal reference or external pin.
// RULE4 - Sample window length is programmable to allow longer settling.
// RULE5 - Eight fixed inputs, each with an enable deciding scan membership.
// RULE6 - Scan steps through enabled channels back to back, no idle clocks.
// RULE7 - Channel chosen by sequencer or directly by firmware, per a setting.
// RULE8 - Each channel keeps its own result register for later reading.
// RULE9 - Each channel has its own sample time, applied when it converts.
// RULE10 - Result outside low/high limits raises out-of-range interrupt at once.
// RULE11 - Temperature sensor is a selectable conversion source.
// RULE12 - Converter is idle in deep sleep and hibernate modes.
// RULE13 - Out-of-range flags stay until cleared; results hold until reconverted.
`timescale 1ns/1ns
module sarseq_top (
  // Clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     nrst_i,
  // AHB-Lite slave
  input  wire logic                     hsel_i,
  input  wire logic [31:0]              haddr_i,
  input  wire logic [1:0]               htrans_i,
  input  wire logic                     hwrite_i,
  input  wire logic [2:0]               hsize_i,
  input  wire logic [31:0]              hwdata_i,
  input  wire logic                     hready_i,
  output logic      [31:0]              hrdata_o,
  output logic                          hreadyout_o,
  output logic                          hresp_o,
  // Analog front end
  input  wire logic                     cmp_i,
  input  wire logic                     lp_mode_i,
  output sarseq_pkg::sarseq_ana_s       ana_o,
  // Out-of-range interrupt
  output logic                          range_irq_o
);
  import sarseq_pkg::*;

  // ==========================================================
  // Declarations
  logic                  ap_wr_ff;
  logic [7:0]            ap_addr_ff;
  logic                  take;
  logic                  en_ff;
  logic                  fw_ff;
  logic                  cont_ff;
  sarseq_ref_e           ref_ff;
  logic [CH_W-1:0]       fwch_ff;
  logic [CH_N-1:0]       chen_ff;
  logic [RES_W-1:0]      lo_ff;
  logic [RES_W-1:0]      hi_ff;
  logic [SMP_W-1:0]      smp_ff   [CH_N];
  logic [RES_W-1:0]      res_ff   [CH_N];
  logic [CH_N-1:0]       valid_ff;
  logic [CH_N-1:0]       oor_ff;
  logic [CH_N-1:0]       nxt_oor;
  sarseq_state_e         seq_ff;
  logic [CH_W-1:0]       chan_ff;
  logic                  tick;
  logic                  abort;
  logic                  core_ack;
  logic                  core_done;
  logic [RES_W-1:0]      core_res;
  logic [CH_W-1:0]       core_mux;
  logic                  core_busy;
  logic                  core_smp;
  logic [RES_W-1:0]      core_trial;
  logic                  wr_ctrl;
  logic                  start_req;
  logic [CH_W-1:0]       nxt_ch;
  logic                  out_range;
  logic [CH_W-1:0]       done_ch_ff;
  logic [SMP_W-1:0]      smp_sel;

  // Next enabled channel after cur, wrapping round
  function automatic logic [CH_W-1:0] next_en(input logic [CH_W-1:0] cur,
                                              input logic [CH_N-1:0] en);
    int idx;
    next_en = cur;
    for (int k = CH_N; k >= 1; k--) begin
      idx = (int'(cur) + k) % CH_N;
      if (en[idx]) begin
        next_en = CH_W'(idx);
      end
    end
  endfunction : next_en

  // ==========================================================
  // Bus slave
  // Zero wait states; a read taken right after a write sees the old value
  assign take    = hsel_i && htrans_i[1] && hready_i;
  assign wr_ctrl = ap_wr_ff && (ap_addr_ff == OFS_CTRL);

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      ap_wr_ff    <= 1'b0;
      ap_addr_ff  <= 8'h00;
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
    end else begin
      ap_wr_ff    <= take && hwrite_i;
      ap_addr_ff  <= haddr_i[7:0];
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (take && !hwrite_i) begin
      hrdata_o <= 32'h0000_0000;
      case (haddr_i[7:0])
        OFS_CTRL: begin
          hrdata_o <= {20'h00000, fwch_ff, 2'b00, ref_ff, cont_ff, 1'b0, fw_ff, en_ff};
        end
        OFS_CHEN: begin
          hrdata_o <= {23'h000000, chen_ff};
        end
        OFS_STATUS: begin
          hrdata_o <= {29'h00000000, range_irq_o, lp_mode_i, (seq_ff == SQ_RUN) || core_busy};
        end
        OFS_RANGE: begin
          hrdata_o <= {4'h0, hi_ff, 4'h0, lo_ff};
        end
        OFS_OOR: begin
          hrdata_o <= {23'h000000, oor_ff};
        end
        default: begin
          for (int i = 0; i < CH_N; i++) begin
            if (haddr_i[7:0] == OFS_SMP0 + 8'(4 * i)) begin
              hrdata_o <= {24'h000000, smp_ff[i]};
            end
            if (haddr_i[7:0] == OFS_RES0 + 8'(4 * i)) begin // see RULE8
              hrdata_o <= {valid_ff[i], 19'h00000, res_ff[i]};
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      en_ff   <= 1'b0;
      fw_ff   <= 1'b0;
      cont_ff <= 1'b0;
      ref_ff  <= REF_VDD;
      fwch_ff <= '0;
    end else if (wr_ctrl) begin
      en_ff   <= hwdata_i[CTRL_EN];
      fw_ff   <= hwdata_i[CTRL_FW];
      cont_ff <= hwdata_i[CTRL_CONT];
      ref_ff  <= sarseq_ref_e'(hwdata_i[CTRL_REF_LO +: 2]); // see RULE3
      fwch_ff <= hwdata_i[CTRL_CH_LO +: CH_W];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      chen_ff <= RST_CHEN;
      lo_ff   <= RST_LO;
      hi_ff   <= RST_HI;
    end else if (ap_wr_ff) begin
      if (ap_addr_ff == OFS_CHEN) begin
        chen_ff <= hwdata_i[CH_N-1:0]; // see RULE5
      end
      if (ap_addr_ff == OFS_RANGE) begin
        lo_ff <= hwdata_i[RES_W-1:0];
        hi_ff <= hwdata_i[RANGE_HI_LO +: RES_W];
      end
    end
  end

  // ==========================================================
  // Per-channel storage
  // Back-to-back loads move the mux before done, so keep the finished channel
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      done_ch_ff <= '0;
    end else if (core_ack) begin
      done_ch_ff <= core_mux; // see RULE8
    end
  end

  assign out_range = (core_res < lo_ff) || (core_res > hi_ff);

  for (genvar g = 0; g < CH_N; g++) begin : g_ch
    logic hit;
    assign hit = core_done && (done_ch_ff == CH_W'(g));
    // A new violation wins over a clear in the same cycle
    assign nxt_oor[g] = (hit && out_range) // see RULE10
                        || (oor_ff[g] && !(ap_wr_ff && (ap_addr_ff == OFS_OOR)
                                           && hwdata_i[g])); // see RULE13

    always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
        smp_ff[g]   <= '0;
        res_ff[g]   <= '0;
        valid_ff[g] <= 1'b0;
        oor_ff[g]   <= 1'b0;
      end else begin
        if (ap_wr_ff && (ap_addr_ff == OFS_SMP0 + 8'(4 * g))) begin
          smp_ff[g] <= hwdata_i[SMP_W-1:0]; // see RULE9
        end
        if (hit) begin // see RULE13
          res_ff[g]   <= core_res;
          valid_ff[g] <= 1'b1;
        end
        oor_ff[g] <= nxt_oor[g];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      range_irq_o <= 1'b0;
    end else begin
      range_irq_o <= |nxt_oor; // see RULE10
    end
  end

  // ==========================================================
  // Sequencer
  assign abort     = lp_mode_i || !en_ff; // see RULE12
  assign start_req = wr_ctrl && hwdata_i[CTRL_START] && hwdata_i[CTRL_EN];
  assign nxt_ch    = next_en(chan_ff, chen_ff);
  // Codes above the last channel have no sample register
  assign smp_sel   = (chan_ff < CH_W'(CH_N)) ? smp_ff[chan_ff] : '0;

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      seq_ff  <= SQ_IDLE;
      chan_ff <= '0;
    end else if (lp_mode_i || (!en_ff && !start_req)) begin
      // One write may enable and start; the enable lands only at this edge
      seq_ff <= SQ_IDLE; // see RULE12
    end else begin
      case (seq_ff)
        SQ_IDLE: begin
          if (start_req && hwdata_i[CTRL_FW]) begin // see RULE7
            seq_ff  <= SQ_RUN;
            chan_ff <= hwdata_i[CTRL_CH_LO +: CH_W]; // see RULE11
          end else if (start_req && (chen_ff != '0)) begin
            seq_ff  <= SQ_RUN;
            chan_ff <= next_en(CH_W'(CH_N - 1), chen_ff);
          end
        end
        SQ_RUN: begin
          if (core_ack) begin
            if (fw_ff) begin
              seq_ff <= SQ_IDLE;
            end else begin
              // Wrap ends a single scan
              if ((nxt_ch <= chan_ff) && !cont_ff) begin
                seq_ff <= SQ_IDLE;
              end
              chan_ff <= nxt_ch; // see RULE6
            end
          end
        end
        default: begin
          seq_ff <= SQ_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Converter
  sarseq_clkdiv #(
    .DIV       (CONV_DIV)
  ) u_div (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .tick_o    (tick) // see RULE2
  );

  sarseq_core u_core (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .tick_i    (tick),
    .abort_i   (abort),
    .go_i      ((seq_ff == SQ_RUN) && !core_ack),
    .chan_i    (chan_ff),
    .smp_len_i (smp_sel), // see RULE9
    .cmp_i     (cmp_i),
    .ack_o     (core_ack),
    .done_o    (core_done),
    .res_o     (core_res),
    .mux_o     (core_mux),
    .busy_o    (core_busy),
    .sample_o  (core_smp),
    .trial_o   (core_trial)
  );

  assign ana_o = '{mux: core_mux, refsel: ref_ff, sample: core_smp, trial: core_trial};

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  logic [9:0] tk_cnt_ff;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      tk_cnt_ff <= '0;
    end else if (core_ack) begin
      // The loading tick is the first converter clock of the conversion
      tk_cnt_ff <= 10'h001;
    end else if (tick && tk_cnt_ff != 10'h3ff) begin
      tk_cnt_ff <= tk_cnt_ff + 1'b1;
    end
  end

  a_tick_spacing: assert property (tick |=> !tick [*5]) // see RULE2
    else $error("converter tick faster than allowed");
  a_conv_length: assert property (core_done |-> tk_cnt_ff >= 10'(MIN_CONV_CLKS)) // see RULE2
    else $error("conversion shorter than minimum");
  a_oor_set: assert property (core_done && out_range // see RULE10
                              |=> oor_ff[$past(done_ch_ff)] && range_irq_o)
    else $error("out-of-range flag not raised");
  a_oor_sticky: assert property (oor_ff[0] && !(ap_wr_ff && ap_addr_ff == OFS_OOR) |=> oor_ff[0]) // see RULE13
    else $error("out-of-range flag dropped");
  a_irq_follow: assert property (range_irq_o == (|oor_ff)) // see RULE10
    else $error("interrupt does not follow flags");
  a_lp_idle: assert property (lp_mode_i |=> seq_ff == SQ_IDLE && !core_busy) // see RULE12
    else $error("converter active in low-power mode");
  a_result_hold: assert property (!(core_done && done_ch_ff == '0) // see RULE13
                                  |=> $stable(res_ff[0]))
    else $error("result changed without conversion");
  a_res_store: assert property (core_done && done_ch_ff == '0 // see RULE8
                                |=> res_ff[0] == $past(core_res) && valid_ff[0])
    else $error("result not stored in its channel");
  a_no_gap: assert property (core_done && $past(seq_ff == SQ_RUN) |-> core_ack) // see RULE6
    else $error("idle converter clock between channels");
  a_fw_chan: assert property (core_ack && fw_ff && !$past(wr_ctrl) |-> core_mux == fwch_ff) // see RULE7
    else $error("firmware channel not applied");

  c_scan_wrap: cover property (core_ack && !fw_ff && nxt_ch < chan_ff);
  c_oor_hit: cover property (core_done && out_range);
  c_temp_conv: cover property (core_done && done_ch_ff == CH_W'(TEMP_CH));
  c_cont_scan: cover property (core_ack && cont_ff && !fw_ff && nxt_ch == chan_ff);
  c_back_to_back: cover property (core_done && core_ack);

endmodule : sarseq_top

// *** design/sarseq_pkg.sv ***
// Constants, types and register map of the converter sequencer.
// Assumes a 100 MHz system clock and an AHB-Lite register bus.
package sarseq_pkg;

  // ==========================================================
  // Converter sizes
  localparam int RES_W   = 12;
  localparam int CH_N    = 9;
  localparam int CH_W    = 4;
  localparam int TEMP_CH = 8;
  localparam int SMP_W   = 8;

  // ==========================================================
  // Timing
  localparam int SYS_CLK_HZ      = 100_000_000;
  localparam int CONV_CLK_MAX_HZ = 18_000_000;
  // Round up so the converter clock never runs above its limit
  localparam int CONV_DIV        = (SYS_CLK_HZ + CONV_CLK_MAX_HZ - 1) / CONV_CLK_MAX_HZ;
  localparam int MIN_CONV_CLKS   = 18;
  localparam int MIN_SMP_CLKS    = MIN_CONV_CLKS - RES_W;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CHEN   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RANGE  = 8'h0c;
  localparam logic [7:0] OFS_OOR    = 8'h10;
  localparam logic [7:0] OFS_SMP0   = 8'h20;
  localparam logic [7:0] OFS_RES0   = 8'h60;

  // ==========================================================
  // Field positions
  localparam int CTRL_EN     = 0;
  localparam int CTRL_FW     = 1;
  localparam int CTRL_START  = 2;
  localparam int CTRL_CONT   = 3;
  localparam int CTRL_REF_LO = 4;
  localparam int CTRL_CH_LO  = 8;
  localparam int RANGE_HI_LO = 16;
  localparam int RES_VALID   = 31;

  // ==========================================================
  // Reset values
  localparam logic [RES_W-1:0] RST_LO   = 12'h000;
  localparam logic [RES_W-1:0] RST_HI   = 12'hfff;
  localparam logic [CH_N-1:0]  RST_CHEN = 9'h000;

  typedef enum logic [1:0] {
    REF_VDD      = 2'b00,
    REF_VDD_HALF = 2'b01,
    REF_INTERNAL = 2'b10,
    REF_EXTERNAL = 2'b11
  } sarseq_ref_e;

  typedef enum logic [0:0] {
    SQ_IDLE = 1'b0,
    SQ_RUN  = 1'b1
  } sarseq_state_e;

  // Analog front-end controls
  typedef struct packed {
    logic [CH_W-1:0]  mux;
    sarseq_ref_e      refsel;
    logic             sample;
    logic [RES_W-1:0] trial;
  } sarseq_ana_s;

endpackage : sarseq_pkg

// *** design/sarseq_clkdiv.sv ***
// Converter clock enable divider.
// Assumes one system clock; produces one-cycle enable pulses.
`timescale 1ns/1ns
module sarseq_clkdiv #(
  parameter int DIV = sarseq_pkg::CONV_DIV
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  // Enable pulse
  output logic      tick_o
);
  import sarseq_pkg::*;

  localparam int CW = $clog2(DIV);

  logic [CW-1:0] cnt_ff;

  if (DIV < 2) begin : g_chk
    $error("sarseq_clkdiv: DIV below 2");
  end

  // ==========================================================
  // Divider
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      cnt_ff <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_ff == CW'(DIV - 1));
      cnt_ff <= (cnt_ff == CW'(DIV - 1)) ? '0 : cnt_ff + 1'b1;
    end
  end

endmodule : sarseq_clkdiv

// *** design/sarseq_core.sv ***
// Successive-approximation engine: sample window then one bit per tick.
// Assumes the comparator input is settled at each converter tick.
`timescale 1ns/1ns
module sarseq_core (
  // Clock and reset
  input  wire logic                         clk_sys_i,
  input  wire logic                         nrst_i,
  // Control
  input  wire logic                         tick_i,
  input  wire logic                         abort_i,
  input  wire logic                         go_i,
  input  wire logic [sarseq_pkg::CH_W-1:0]  chan_i,
  input  wire logic [sarseq_pkg::SMP_W-1:0] smp_len_i,
  input  wire logic                         cmp_i,
  // Results, status and analog controls
  output logic                              ack_o,
  output logic                              done_o,
  output logic [sarseq_pkg::RES_W-1:0]      res_o,
  output logic [sarseq_pkg::CH_W-1:0]       mux_o,
  output logic                              busy_o,
  output logic                              sample_o,
  output logic [sarseq_pkg::RES_W-1:0]      trial_o
);
  import sarseq_pkg::*;

  localparam int BW = $clog2(RES_W);

  logic [SMP_W:0]  cnt_ff;
  logic [BW-1:0]   bit_ff;
  logic            last;
  logic [RES_W-1:0] kept;

  assign last = busy_o && !sample_o && (bit_ff == '0);
  assign kept = cmp_i ? trial_o : (trial_o & ~(RES_W'(1) << bit_ff));

  // ==========================================================
  // Conversion sequence
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      ack_o    <= 1'b0;
      done_o   <= 1'b0;
      res_o    <= '0;
      mux_o    <= '0;
      busy_o   <= 1'b0;
      sample_o <= 1'b0;
      trial_o  <= '0;
      cnt_ff   <= '0;
      bit_ff   <= '0;
    end else if (abort_i) begin
      ack_o    <= 1'b0;
      done_o   <= 1'b0;
      busy_o   <= 1'b0;
      sample_o <= 1'b0;
    end else begin
      ack_o  <= 1'b0;
      done_o <= 1'b0;
      if (tick_i) begin
        if (last) begin
          done_o <= 1'b1;
          res_o  <= kept;
          busy_o <= 1'b0;
        end
        // Loading on the last bit tick leaves no idle converter clock
        if ((!busy_o || last) && go_i) begin // see RULE6
          ack_o    <= 1'b1;
          busy_o   <= 1'b1;
          sample_o <= 1'b1;
          mux_o    <= chan_i;
          cnt_ff   <= (SMP_W+1)'(MIN_SMP_CLKS - 1) + {1'b0, smp_len_i}; // see RULE9
          trial_o  <= '0;
        end else if (sample_o) begin
          cnt_ff <= cnt_ff - 1'b1;
          if (cnt_ff == '0) begin // see RULE4
            sample_o <= 1'b0;
            bit_ff   <= BW'(RES_W - 1);
            trial_o  <= RES_W'(1) << (RES_W - 1);
          end
        end else if (busy_o && !last) begin // see RULE1
          bit_ff  <= bit_ff - 1'b1;
          trial_o <= kept | (RES_W'(1) << (bit_ff - 1'b1));
        end
      end
    end
  end

endmodule : sarseq_core

// *** tb/sarseq_afe_model.sv ***
// Behavioural analog front end: input levels, track-and-hold, comparator.
// Assumes levels are given as codes of whichever reference is selected.
`timescale 1ns/1ns
module sarseq_afe_model (
  // Clock and reset
  input  wire logic                                              clk_sys_i,
  input  wire logic                                              nrst_i,
  // Converter controls and input levels
  input  wire sarseq_pkg::sarseq_ana_s                           ana_i,
  input  wire logic [sarseq_pkg::CH_N-1:0][sarseq_pkg::RES_W-1:0] lvl_i,
  // Comparator
  output logic                                                   cmp_o
);
  import sarseq_pkg::*;
  // ==========================================================
  // Track and hold
  logic [RES_W-1:0] held_ff;
  logic             noise_ff;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      held_ff  <= '0;
      noise_ff <= 1'b0;
    end else begin
      noise_ff <= ~noise_ff;
      if (ana_i.sample) begin
        // Unused codes give a moving value, not a kind one
        held_ff <= (ana_i.mux < CH_N) ? lvl_i[ana_i.mux] : ~held_ff;
      end
    end
  end
  // ==========================================================
  // Comparator, meaningless while tracking
  assign cmp_o = ana_i.sample ? noise_ff : (held_ff >= ana_i.trial);
endmodule : sarseq_afe_model

// *** tb/tb.sv ***
// Self-checking bench of the converter sequencer over AHB-Lite.
// Assumes zero-wait-state slave and the analog model on the far side.
`timescale 1ns/1ns
module tb;
  import sarseq_pkg::*;
  // ==========================================================
  // Signals
  logic                        clk_sys_i = 1'b0;
  logic                        nrst_i    = 1'b0;
  logic                        hsel_i    = 1'b0;
  logic [31:0]                 haddr_i   = '0;
  logic [1:0]                  htrans_i  = 2'b00;
  logic                        hwrite_i  = 1'b0;
  logic [2:0]                  hsize_i   = 3'b010;
  logic [31:0]                 hwdata_i  = '0;
  logic [31:0]                 hrdata_o;
  logic                        hreadyout_o;
  logic                        hresp_o;
  logic                        cmp_i;
  logic                        lp_mode_i = 1'b0;
  sarseq_ana_s                 ana_o;
  logic                        range_irq_o;
  logic [CH_N-1:0][RES_W-1:0]  lvl = '0;
  logic [31:0]                 rd_q;
  logic [31:0]                 rv;
  int                          smp_cnt;
  int                          s0;
  int                          fail_count   = 0;
  int                          total_checks = 0;

  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) rd_q <= hrdata_o;
  always @(posedge clk_sys_i) if (ana_o.sample === 1'b1) smp_cnt <= smp_cnt + 1;

  sarseq_top uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .cmp_i(cmp_i), .lp_mode_i(lp_mode_i), .ana_o(ana_o),
    .range_irq_o(range_irq_o));
  sarseq_afe_model afe (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ana_i(ana_o),
    .lvl_i(lvl), .cmp_o(cmp_i));

  // ==========================================================
  // Bus tasks
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel_i <= 1'b1; haddr_i <= {24'h000000, a}; htrans_i <= 2'b10; hwrite_i <= wr;
    @(posedge clk_sys_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
    htrans_i <= 2'b00; hsel_i <= 1'b0; hwdata_i <= d;
    @(posedge clk_sys_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
    #1 rv = rd_q;
    if (hresp_o !== 1'b0) chk("hresp", 32'h0, {31'h0, hresp_o});
  endtask : bus
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    chk(n, e, rv);
  endtask : rchk
  // Start, then wait for busy to rise and fall, bounded
  task automatic run(input logic [31:0] ctrl);
    int k;
    smp_cnt = 0;
    bus(1'b1, OFS_CTRL, ctrl);
    k = 0;
    do begin bus(1'b0, OFS_STATUS, '0); k++; end while (rv[0] !== 1'b1 && k < 20);
    do begin bus(1'b0, OFS_STATUS, '0); k++; end while (rv[0] !== 1'b0 && k < 2000);
    if (k >= 2000) chk("busy timeout", 32'h0, 32'h1);
  endtask : run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  initial begin
    #500_000;
    fail_count++;
    stop_test();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    rchk("chen rst", OFS_CHEN, 32'h0);
    rchk("range rst", OFS_RANGE, 32'h0fff0000);
    rchk("oor rst", OFS_OOR, 32'h0);
    rchk("status rst", OFS_STATUS, 32'h0);
    rchk("unmapped", 8'hfc, 32'h0);
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, OFS_CTRL, 32'h1 | (r << 4));
      chk("refsel", r, {30'h0, ana_o.refsel});
    end
    rchk("ctrl rb", OFS_CTRL, 32'h31);
    lvl[0] = 12'h050; lvl[1] = 12'h5a5; lvl[2] = 12'h7a3; lvl[8] = 12'hf10;
    bus(1'b1, OFS_RANGE, 32'h0e000100);
    bus(1'b1, OFS_CHEN, 32'h105);
    bus(1'b1, OFS_SMP0 + 8'h08, 32'h3);
    run(32'h5);
    rchk("res0", OFS_RES0, 32'h80000050);
    rchk("res1 skipped", OFS_RES0 + 8'h04, 32'h0);
    rchk("res2", OFS_RES0 + 8'h08, 32'h800007a3);
    rchk("res8 temp", OFS_RES0 + 8'h20, 32'h80000f10);
    rchk("oor", OFS_OOR, 32'h101);
    chk("irq", 32'h1, {31'h0, range_irq_o});
    bus(1'b1, OFS_OOR, 32'h1);
    rchk("oor part", OFS_OOR, 32'h100);
    chk("irq held", 32'h1, {31'h0, range_irq_o});
    bus(1'b1, OFS_OOR, 32'h100);
    chk("irq clr", 32'h0, {31'h0, range_irq_o});
    run(32'h107);
    s0 = smp_cnt;
    rchk("res1 fw", OFS_RES0 + 8'h04, 32'h800005a5);
    rchk("res0 held", OFS_RES0, 32'h80000050);
    chk("min window", 32'h1, {31'h0, s0 >= 6 * CONV_DIV});
    bus(1'b1, OFS_SMP0 + 8'h04, 32'h4);
    run(32'h107);
    chk("smp extend", 4 * CONV_DIV, smp_cnt - s0);
    lvl[1] = 12'h333;
    bus(1'b1, OFS_CHEN, 32'h2);
    bus(1'b1, OFS_CTRL, 32'hd);
    repeat (300) @(posedge clk_sys_i);
    rchk("cont busy", OFS_STATUS, 32'h1);
    bus(1'b1, OFS_CTRL, 32'h0);
    @(posedge clk_sys_i);
    rchk("cont stop", OFS_STATUS, 32'h0);
    rchk("res1 cont", OFS_RES0 + 8'h04, 32'h80000333);
    lvl[1] = 12'h444;
    run(32'h107);
    rchk("res1 start", OFS_RES0 + 8'h04, 32'h80000444);
    lp_mode_i <= 1'b1;
    rchk("status lp", OFS_STATUS, 32'h2);
    bus(1'b1, OFS_CTRL, 32'h5);
    repeat (40) @(posedge clk_sys_i);
    rchk("lp idle", OFS_STATUS, 32'h2);
    lp_mode_i <= 1'b0;
    stop_test();
  end
endmodule : tb
